/* test/core_model.sv */
// Behavioural instruction stepper standing in for the processor core
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // Pacing and entry
    input  wire logic [7:0]  gap_in,
    input  wire logic        take_in,
    output logic             step_out,
    output logic [12:0]      pc_out
);
    logic [7:0] cnt_reg;
    // ----------------------------------------
    // Variable pacing mimics mixed instruction lengths
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        step_out <= 1'b0;
        if (sys_rst_in) begin
            cnt_reg <= 8'h00;
            pc_out <= 13'h0000;
        end else begin
            if (cnt_reg >= gap_in) begin
                cnt_reg <= 8'h00;
                step_out <= 1'b1;
                pc_out <= pc_out + 13'h0001;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            if (take_in) begin
                pc_out <= 13'h0004;
            end
        end
    end
endmodule

/* test/irq_chk.sv */
// Concurrent checks on the ports of the interrupt logic
`timescale 1ns/1ps
module irq_chk #(
    parameter PC_WIDTH = 13
) (
    // Clock and reset
    input  wire                ref_clk_in,
    input  wire                sys_rst_in,
    // Watched signals
    input  wire                hreadyout,
    input  wire                hresp,
    input  wire                sleep_instr_in,
    input  wire                irq_take_out,
    input  wire                push_out,
    input  wire [PC_WIDTH-1:0] vector_out,
    input  wire                sleep_nop_out,
    input  wire                sleeping_out,
    input  wire                wake_out
);
    default clocking dcb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ----------------------------------------
    // Entry is one pulse; global enable drops with it
    // ----------------------------------------
    sequence s_entry;
        irq_take_out && push_out;
    endsequence
    sequence s_quiet;
        !irq_take_out [*2];
    endsequence
    a_entry_push: assert property ($rose(irq_take_out) |-> s_entry)
        else $error("entry without push");
    a_entry_single: assert property (s_entry |=> s_quiet)
        else $error("entry repeated while disabled");
    a_fixed_vector: assert property (vector_out == 4)
        else $error("vector moved");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    a_no_take_asleep: assert property (irq_take_out |-> !sleeping_out)
        else $error("vector taken while asleep");
    a_nop_awake: assert property (sleep_nop_out |-> !sleeping_out)
        else $error("nop sleep still slept");
    a_nop_cause: assert property (sleep_nop_out |-> $past(sleep_instr_in) || $past(sleep_instr_in, 2))
        else $error("nop without sleep request");
    a_sleep_cause: assert property ($rose(sleeping_out) |-> $past(sleep_instr_in) || $past(sleep_instr_in, 2))
        else $error("sleep without request");
    a_wake_ends: assert property (wake_out |-> ##[0:1] !sleeping_out)
        else $error("wake left core asleep");
    a_wake_source: assert property (wake_out |-> sleeping_out || $past(sleeping_out))
        else $error("wake while awake");
endmodule
bind mcu_interrupt_logic irq_chk #(.PC_WIDTH(PC_WIDTH)) i_irq_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_instr_in(sleep_instr_in), .irq_take_out(irq_take_out), .push_out(push_out),
    .vector_out(vector_out), .sleep_nop_out(sleep_nop_out), .sleeping_out(sleeping_out),
    .wake_out(wake_out));

/* test/mcu_interrupt_logic_test.sv */
// Self-checking bench for the interrupt logic
`timescale 1ns/1ps
`include "irq_consts.vh"
module mcu_interrupt_logic_test;
    logic        ref_clk_in = 0, sys_rst_in = 1, hsel = 0, hwrite = 0, rd_dp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, e, r;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, ret = 0, slp = 0, ext = 1, t0 = 0;
    logic        step, take, push, nop, sleeping, wake;
    logic [3:0]  pins = 0;
    logic [7:0]  ev1 = 0, ev2 = 0, gap = 8'h02;
    logic [12:0] pc, paddr, vec, pc_q;
    logic [31:0] q[$];
    int          fail_count = 0, checks_done = 0;
    wire  [3:0]  flg = {nop, wake, sleeping, take};
    always #2.5 ref_clk_in = ~ref_clk_in;
    mcu_interrupt_logic i_mcu_interrupt_logic (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .instr_step_in(step), .return_from_irq_instr_in(ret),
        .sleep_instr_in(slp), .next_pc_in(pc), .irq_take_out(take), .push_addr_out(paddr),
        .push_out(push), .vector_out(vec), .sleep_nop_out(nop), .sleeping_out(sleeping),
        .wake_out(wake), .ext_irq_pin_in(ext), .upper_port_pins_in(pins),
        .timer0_wrap_in(t0), .periph_evt_1_in(ev1), .periph_evt_2_in(ev2));
    core_model i_core_model (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .gap_in(gap),
        .take_in(take), .step_out(step), .pc_out(pc));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        @(posedge ref_clk_in);
        while (hreadyout !== 1'b1) @(posedge ref_clk_in);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk_in);
        while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        bus(0, a, 32'h0);
    endtask
    task wt(input int b, input int n);
        for (int i = 0; i < 400 && flg[b] !== 1'b1; i++) @(posedge ref_clk_in);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // Each cycle with a read data phase or a vector entry, or both, consumes the oldest note
    always @(posedge ref_clk_in) begin
        if (rd_dp || take) begin
            e = (q.size() > 0) ? q.pop_front() : 32'hxxxxxxxx;
            chk(rd_dp ? hrdata : {19'h0, vec}, e);
        end
        if (take) begin
            chk(paddr, {19'h0, pc_q});
            chk(push, 1'b1);
        end
        pc_q <= pc;
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        #100000;
        fail_count++;
        conclude;
    end
    initial begin
        r = $urandom(32'he16a);
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 0;
        rd(`ADDR_IRQ_CONTROL, 32'h00);
        rd(`ADDR_OPTION, 32'hff);
        rd(8'h1c, 32'h0);
        rd(`ADDR_PERIPH_EN_1, 32'h00);
        bus(1, `ADDR_PERIPH_EN_1, 32'hff);
        rd(`ADDR_PERIPH_EN_1, 32'h7f);
        for (int i = 0; i < 3; i++) begin
            bus(1, `ADDR_OPTION, i ? 32'hff : 32'h00);
            ext <= ~ext;
            repeat (6) @(posedge ref_clk_in);
            rd(`ADDR_IRQ_CONTROL, (i < 2) ? 32'h02 : 32'h00);
            bus(1, `ADDR_IRQ_CONTROL, 32'h0);
        end
        t0 <= 1;
        pins <= 4'($urandom) | 4'h1;
        repeat (6) @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CONTROL, 32'h05);
        bus(1, `ADDR_IRQ_CONTROL, 32'h0);
        r = $urandom;
        ev1 <= r[7:0] | 8'h01;
        ev2 <= r[15:8];
        gap <= 8'($urandom_range(1, 4));
        @(posedge ref_clk_in);
        ev1 <= 0;
        ev2 <= 0;
        rd(`ADDR_PERIPH_FLAG_1, {24'h0, r[7:0] | 8'h01});
        rd(`ADDR_PERIPH_FLAG_2, {24'h0, r[15:8] & 8'h5b});
        bus(1, `ADDR_PERIPH_EN_1, 32'h01);
        bus(1, `ADDR_IRQ_CONTROL, 32'h80);
        repeat (20) @(posedge ref_clk_in);
        q.push_back(32'h4);
        bus(1, `ADDR_IRQ_CONTROL, 32'hc0);
        wt(0, 1);
        rd(`ADDR_IRQ_CONTROL, 32'h40);
        bus(1, `ADDR_PERIPH_FLAG_1, 32'h0);
        ret <= 1;
        @(posedge ref_clk_in);
        ret <= 0;
        @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CONTROL, 32'hc0);
        sys_rst_in <= 1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 0;
        rd(`ADDR_IRQ_CONTROL, 32'h00);
        bus(1, `ADDR_IRQ_CONTROL, 32'h10);
        slp <= 1;
        @(posedge ref_clk_in);
        slp <= 0;
        wt(1, 0);
        chk(sleeping, 1'b1);
        ext <= ~ext;
        wt(2, 0);
        chk(wake, 1'b1);
        repeat (4) @(posedge ref_clk_in);
        slp <= 1;
        @(posedge ref_clk_in);
        slp <= 0;
        wt(3, 0);
        chk(nop, 1'b1);
        chk(sleeping, 1'b0);
        repeat (4) @(posedge ref_clk_in);
        chk(q.size(), 32'h0);
        conclude;
    end
endmodule

/* verilog/edge_detect.v */
// Two-stage synchroniser with rising/falling edge pulse selection
`timescale 1ns/1ps
module edge_detect #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             ref_clk_in,
    input  wire             sys_rst_in,
    // Asynchronous input
    input  wire [WIDTH-1:0] sig_in,
    // Edge selection: 1 rising, 0 falling; any selects both edges
    input  wire             rise_sel_in,
    input  wire             any_in,
    // Outputs
    output reg  [WIDTH-1:0] edge_out,
    output wire [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] sync1_reg;
    reg [WIDTH-1:0] sync2_reg;
    reg [WIDTH-1:0] prev_reg;
    assign level_out = sync2_reg;

    always @(posedge ref_clk_in) begin
        // Stages keep sampling in reset so release starts at the pin's level
        sync1_reg <= sig_in;
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
        if (sys_rst_in)
            edge_out <= {WIDTH{1'b0}};
        else if (any_in)
            edge_out <= sync2_reg ^ prev_reg;
        else if (rise_sel_in)
            edge_out <= sync2_reg & ~prev_reg;
        else
            edge_out <= ~sync2_reg & prev_reg;
    end
endmodule

/* verilog/irq_consts.vh */
// Register offsets, bit positions, reset values and timing counts of the interrupt logic
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

// Register byte addresses on the bus
`define ADDR_IRQ_CONTROL    8'h00
`define ADDR_PERIPH_FLAG_1  8'h04
`define ADDR_PERIPH_FLAG_2  8'h08
`define ADDR_PERIPH_EN_1    8'h0c
`define ADDR_PERIPH_EN_2    8'h10
`define ADDR_OPTION         8'h14
`define ADDR_CORE_STATUS    8'h18

// Control register fields
`define BIT_GLOBAL_EN       7
`define BIT_PERIPH_EN       6
`define BIT_T0_EN           5
`define BIT_EXT_EN          4
`define BIT_PC_EN           3
`define BIT_T0_FLAG         2
`define BIT_EXT_FLAG        1
`define BIT_PC_FLAG         0

// Option register field
`define BIT_EDGE_SEL        6

// Reset values and write masks
`define RST_IRQ_CONTROL     8'h00
`define RST_PERIPH          8'h00
`define RST_OPTION          8'hff
`define MASK_PERIPH_EN_1    8'h7f
`define MASK_PERIPH_2       8'h5b

// Vector and event-to-vector delay in instruction cycles
`define IRQ_VECTOR          13'h0004
`define LATENCY_CYCLES      3'h3

`endif

/* verilog/mcu_interrupt_logic.v */
// Interrupt flags, enables, vectoring and sleep wake-up of an 8-bit controller
//
// Behaviour
// [RL1] Each flag sets on its event regardless of any enable bit.
// [RL2] Control bit 7 is global enable; clear blocks every interrupt. A pending request whose step count has reached zero still enters.
// [RL3] Global enable plus any flag with its enable set takes the interrupt.
// [RL4] Every reset clears the global enable.
// [RL5] Return-from-interrupt leaves the routine and sets the global enable.
// [RL6] Entry clears global enable, pushes return address, loads fixed vector.
// [RL7] Peripheral flags/enables in two register pairs; peripheral enable in control.
// [RL8] Software clears serviced flags before re-enabling, else interrupt recurs.
// [RL9] Pin and port-change events reach the vector in three or four cycles.
// [RL10] External pin triggers rising when option bit 6 set, else falling.
// [RL11] Valid pin edge sets control bit 1; bit 4 enables it.
// [RL12] Pin interrupt wakes from sleep if enabled; global enable decides vectoring.
// [RL13] Timer0 rollover from ff to 00 sets control bit 2; bit 5 enables.
// [RL14] Change on port pins 7:4 sets control bit 0; enable position unresolved.
// [RL15] Only the return address is saved; working and status registers are not.
// [RL16] Up to fifteen sources, each with its own flag and enable.
// [RL17] First peripheral enable resets to zero, top bit reserved and kept clear.
// [RL18] Enabled interrupt wakes regardless of global enable; vector after next instruction.
// [RL19] Sleep with an enabled flag already pending completes as no-operation.
// [RL20] Peripheral source requests only with flag, enable, peripheral and global enable.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "irq_consts.vh"
module mcu_interrupt_logic #(
    parameter PC_WIDTH = 13
) (
    // Clock and reset
    input  wire                ref_clk_in,
    input  wire                sys_rst_in,
    // AHB-Lite slave
    input  wire                hsel,
    input  wire [31:0]         haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output reg  [31:0]         hrdata,
    output reg                 hreadyout,
    output reg                 hresp,
    // Core side
    input  wire                instr_step_in,
    input  wire                return_from_irq_instr_in,
    input  wire                sleep_instr_in,
    input  wire [PC_WIDTH-1:0] next_pc_in,
    output reg                 irq_take_out,
    output reg  [PC_WIDTH-1:0] push_addr_out,
    output reg                 push_out,
    output reg  [PC_WIDTH-1:0] vector_out,
    output reg                 sleep_nop_out,
    output reg                 sleeping_out,
    output reg                 wake_out,
    // Event sources
    input  wire                ext_irq_pin_in,
    input  wire [3:0]          upper_port_pins_in,
    input  wire                timer0_wrap_in,
    input  wire [7:0]          periph_evt_1_in,
    input  wire [7:0]          periph_evt_2_in
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [7:0]  irq_control_reg;
    reg  [7:0]  periph_flag_reg_1;
    reg  [7:0]  periph_flag_reg_2;
    reg  [7:0]  periph_enable_reg_1;
    reg  [7:0]  periph_enable_reg_2;
    reg  [7:0]  option_reg;
    reg  [2:0]  wait_cnt_reg;
    reg         pending_reg;
    reg         defer_reg;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg         t0_prev_reg;

    // ---------------------------------------------------------------
    // Next-state values
    // ---------------------------------------------------------------
    reg  [7:0]  irq_control_next;
    reg  [7:0]  periph_flag_1_next;
    reg  [7:0]  periph_flag_2_next;
    reg  [7:0]  periph_enable_1_next;
    reg  [7:0]  periph_enable_2_next;
    reg  [7:0]  option_next;
    reg  [31:0] hrdata_next;

    // ---------------------------------------------------------------
    // Internal nets
    // ---------------------------------------------------------------
    wire        ext_edge;
    wire [3:0]  pc_edge;
    wire        ext_level;
    wire [3:0]  pc_level;
    wire [15:0] periph_hit;
    wire [31:0] status_word;
    wire        global_irq_enable;
    wire        periph_irq_enable;
    wire        t0_ev;
    wire        ext_hit;
    wire        t0_hit;
    wire        pc_hit;
    wire        core_any;
    wire        enabled_any;
    wire        request;
    wire        entry;
    wire        bus_req;
    wire [7:0]  wd;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    edge_detect #(.WIDTH(1)) u_ext (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .sig_in      (ext_irq_pin_in),
        .rise_sel_in (option_reg[`BIT_EDGE_SEL]), // RL10
        .any_in      (1'b0),
        .edge_out    (ext_edge),
        .level_out   (ext_level)
    );

    edge_detect #(.WIDTH(4)) u_pc (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .sig_in      (upper_port_pins_in),
        .rise_sel_in (1'b0),
        .any_in      (1'b1),
        .edge_out    (pc_edge),
        .level_out   (pc_level)
    );

    // ---------------------------------------------------------------
    // Request evaluation
    // ---------------------------------------------------------------
    assign global_irq_enable = irq_control_reg[`BIT_GLOBAL_EN];
    assign periph_irq_enable = irq_control_reg[`BIT_PERIPH_EN];
    // Timer wrap is a same-clock level; its rising edge is the rollover
    assign t0_ev             = timer0_wrap_in & ~t0_prev_reg;
    assign ext_hit           = irq_control_reg[`BIT_EXT_FLAG] & irq_control_reg[`BIT_EXT_EN];
    assign t0_hit            = irq_control_reg[`BIT_T0_FLAG] & irq_control_reg[`BIT_T0_EN];
    assign pc_hit            = irq_control_reg[`BIT_PC_FLAG] & irq_control_reg[`BIT_PC_EN];

    // One flag-and-enable term per peripheral bit of both register pairs
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_periph_hit
            assign periph_hit[gi]     = periph_flag_reg_1[gi] & periph_enable_reg_1[gi];
            assign periph_hit[gi + 8] = periph_flag_reg_2[gi] & periph_enable_reg_2[gi];
        end
    endgenerate

    // Enabled-and-flagged irrespective of global enable, used for wake
    assign core_any    = ext_hit | t0_hit | pc_hit;
    assign enabled_any = core_any | (periph_irq_enable & (|periph_hit)); // RL20
    assign request     = global_irq_enable & enabled_any; // RL2 RL3
    // Entry needs an awake core; clearing the enable while asleep would strand it
    assign entry       = pending_reg & (wait_cnt_reg == 3'h0) & ~defer_reg & ~sleeping_out;

    // Core status: sleep state and synchronised pin levels
    assign status_word = {25'h0000000, sleeping_out, ext_level, 1'b0, pc_level};

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    // Word transfers only; hsize is not decoded
    assign bus_req = hsel & hready & htrans[1];
    assign wd      = hwdata[7:0];

    // ---------------------------------------------------------------
    // Flag, enable and option next state; hardware flag set wins over software clear
    // ---------------------------------------------------------------
    always @* begin
        irq_control_next     = irq_control_reg;
        periph_flag_1_next   = periph_flag_reg_1;
        periph_flag_2_next   = periph_flag_reg_2;
        periph_enable_1_next = periph_enable_reg_1;
        periph_enable_2_next = periph_enable_reg_2;
        option_next          = option_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `ADDR_IRQ_CONTROL:   irq_control_next = wd;
                `ADDR_PERIPH_FLAG_1: periph_flag_1_next = wd;
                `ADDR_PERIPH_FLAG_2: periph_flag_2_next = wd & `MASK_PERIPH_2;
                `ADDR_PERIPH_EN_1:   periph_enable_1_next = wd & `MASK_PERIPH_EN_1; // RL17
                `ADDR_PERIPH_EN_2:   periph_enable_2_next = wd & `MASK_PERIPH_2;
                `ADDR_OPTION:        option_next = wd;
                default: ;
            endcase
        end
        if (return_from_irq_instr_in)
            irq_control_next[`BIT_GLOBAL_EN] = 1'b1; // RL5
        if (entry)
            irq_control_next[`BIT_GLOBAL_EN] = 1'b0; // RL6
        // Sources set flags with no regard to enables
        if (ext_edge)
            irq_control_next[`BIT_EXT_FLAG] = 1'b1; // RL1 RL11
        if (t0_ev)
            irq_control_next[`BIT_T0_FLAG] = 1'b1; // RL13
        if (|pc_edge)
            irq_control_next[`BIT_PC_FLAG] = 1'b1; // RL14
        periph_flag_1_next = periph_flag_1_next | periph_evt_1_in; // RL1 RL7
        periph_flag_2_next = periph_flag_2_next | (periph_evt_2_in & `MASK_PERIPH_2);
    end

    // ---------------------------------------------------------------
    // Read data; a read sees a write still in its data phase
    // ---------------------------------------------------------------
    always @* begin
        case (haddr[7:0])
            `ADDR_IRQ_CONTROL:   hrdata_next = {24'h000000, irq_control_next};
            `ADDR_PERIPH_FLAG_1: hrdata_next = {24'h000000, periph_flag_1_next};
            `ADDR_PERIPH_FLAG_2: hrdata_next = {24'h000000, periph_flag_2_next};
            `ADDR_PERIPH_EN_1:   hrdata_next = {24'h000000, periph_enable_1_next};
            `ADDR_PERIPH_EN_2:   hrdata_next = {24'h000000, periph_enable_2_next};
            `ADDR_OPTION:        hrdata_next = {24'h000000, option_next};
            `ADDR_CORE_STATUS:   hrdata_next = status_word;
            default:             hrdata_next = 32'h00000000;
        endcase
    end

    // ---------------------------------------------------------------
    // Register update
    // ---------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        // Follows the input during reset too, so release shows no false rollover
        t0_prev_reg <= timer0_wrap_in;
        if (sys_rst_in) begin
            irq_control_reg     <= `RST_IRQ_CONTROL; // RL4
            periph_flag_reg_1   <= `RST_PERIPH;
            periph_flag_reg_2   <= `RST_PERIPH;
            periph_enable_reg_1 <= `RST_PERIPH; // RL17
            periph_enable_reg_2 <= `RST_PERIPH;
            option_reg          <= `RST_OPTION;
        end else begin
            irq_control_reg     <= irq_control_next;
            periph_flag_reg_1   <= periph_flag_1_next;
            periph_flag_reg_2   <= periph_flag_2_next;
            periph_enable_reg_1 <= periph_enable_1_next;
            periph_enable_reg_2 <= periph_enable_2_next;
            option_reg          <= option_next;
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite write capture: the write commits at the end of its data phase
    // ---------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= bus_req & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite response: zero wait states, always OKAY
    // ---------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (bus_req && !hwrite)
                hrdata <= hrdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Vectoring: latency counted in instruction steps, only PC is pushed
    // ---------------------------------------------------------------
    // Fixed step count; where the event lands gives the three-or-four spread
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pending_reg   <= 1'b0;
            wait_cnt_reg  <= 3'h0;
            defer_reg     <= 1'b0;
            irq_take_out  <= 1'b0;
            push_out      <= 1'b0;
            push_addr_out <= {PC_WIDTH{1'b0}};
            vector_out    <= `IRQ_VECTOR;
        end else begin
            irq_take_out <= 1'b0;
            push_out     <= 1'b0;
            if (!pending_reg) begin
                if (request) begin
                    pending_reg  <= 1'b1;
                    // Counts instruction steps so one- and two-cycle instructions match
                    wait_cnt_reg <= `LATENCY_CYCLES - 3'h1; // RL9
                end
            end else if (!request && wait_cnt_reg != 3'h0) begin
                // Request withdrawn by software while the step count is still running
                pending_reg <= 1'b0;
            end else if (wait_cnt_reg != 3'h0) begin
                if (instr_step_in && !sleeping_out)
                    wait_cnt_reg <= wait_cnt_reg - 3'h1; // RL9
            end else if (defer_reg) begin
                // After wake, instruction following sleep executes first
                if (instr_step_in)
                    defer_reg <= 1'b0; // RL18
            end else if (entry) begin
                pending_reg   <= 1'b0;
                irq_take_out  <= 1'b1; // RL3
                push_out      <= 1'b1; // RL6 RL15
                push_addr_out <= next_pc_in; // RL6
                vector_out    <= `IRQ_VECTOR; // RL6
            end
            // Wake decides here whether one instruction runs before the vector
            if (wake_out)
                defer_reg <= global_irq_enable; // RL18
        end
    end

    // ---------------------------------------------------------------
    // Sleep: a pending enabled flag turns sleep into a no-operation
    // ---------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sleeping_out  <= 1'b0;
            wake_out      <= 1'b0;
            sleep_nop_out <= 1'b0;
        end else begin
            wake_out      <= 1'b0;
            sleep_nop_out <= 1'b0;
            if (sleep_instr_in && !sleeping_out) begin
                if (enabled_any)
                    sleep_nop_out <= 1'b1; // RL19
                else
                    sleeping_out <= 1'b1;
            end else if (sleeping_out && enabled_any) begin
                // Wake ignores the global enable
                sleeping_out <= 1'b0; // RL12 RL18
                wake_out     <= 1'b1;
            end
        end
    end
endmodule
